//--- lsm_consts.vh
// Constants for the load/store and multiple-transfer unit
`ifndef LSM_CONSTS_VH
`define LSM_CONSTS_VH
// Operation codes on opCode
`define OP_LOAD_WORD 4'h0
`define OP_LOAD_BYTE_ZX 4'h1
`define OP_LOAD_HALF_ZX 4'h2
`define OP_LOAD_BYTE_SX 4'h3
`define OP_LOAD_HALF_SX 4'h4
`define OP_STORE_WORD 4'h5
`define OP_STORE_BYTE 4'h6
`define OP_STORE_HALF 4'h7
`define OP_LOAD_LITERAL 4'h8
`define OP_LOAD_MULTIPLE 4'h9
`define OP_STORE_MULTIPLE 4'ha
`define OP_PUSH 4'hb
`define OP_POP 4'hc
// Address step and literal reach
`define WORD_BYTES 32'h00000004
`define LITERAL_MAX_OFFSET 32'h000003fc
// Byte strobes
`define STORE_BYTE_OP_WORD 4'hf
`define STORE_BYTE_OP_HALF 4'h3
`define STORE_BYTE_OP_BYTE 4'h1
// Register numbers
`define REG_SP 4'hd
`define REG_LR 4'he
`define REG_PC 4'hf
`endif

//--- load_store_multiple_unit.v
// Load/store, multiple-transfer and stack push/pop execution unit
`timescale 1ns/1ps
`default_nettype none
`include "lsm_consts.vh"

module load_store_multiple_unit #(
  parameter ADDR_W = 32
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Instruction issue
  input wire issueValid,
  output wire issueReady,
  input wire [3:0] opCode,
  input wire [2:0] transferReg,
  input wire [2:0] baseReg,
  input wire [2:0] offsetReg,
  input wire [9:0] literalOffset,
  input wire [7:0] regList,
  input wire listExtra,
  input wire writeBack,
  input wire [31:0] programCounter,
  input wire [31:0] stackPointer,
  // Register file read ports
  output wire [3:0] readAddrA,
  input wire [31:0] readDataA,
  output wire [3:0] readAddrB,
  input wire [31:0] readDataB,
  // Register file write port
  output reg rfWriteEn,
  output reg [3:0] rfWriteAddr,
  output reg [31:0] rfWriteData,
  // Data bus
  output reg memReq,
  output reg memWrite,
  output reg [ADDR_W-1:0] memAddr,
  output reg [3:0] memStrobe,
  output reg [31:0] memWdata,
  input wire memAck,
  input wire [31:0] memRdata,
  // Completion, branch and fault
  output reg doneOut,
  output reg branchOut,
  output reg [31:0] branchTarget,
  output reg thumbBit,
  output reg faultOut,
  output wire flagsWriteEn
);

  ////////////////////////////////////////////////////////////////////////
  // States, one-hot
  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_READ = 5'b00010;
  localparam [4:0] ST_BUS = 5'b00100;
  localparam [4:0] ST_FIN = 5'b01000;
  // Gap between list words, so port A can follow the next register
  localparam [4:0] ST_NEXT = 5'b10000;

  reg [4:0] state_r;
  reg [3:0] op_r;
  reg [2:0] xfer_r;
  reg [2:0] base_r;
  reg [2:0] offs_r;
  reg [9:0] lit_r;
  reg [8:0] list_r;
  reg wb_r;
  reg [31:0] addr_r;
  reg [31:0] endSp_r;
  reg pcLoaded_r;
  reg [31:0] pcVal_r;
  // Store source, read at issue since both ports form the address later
  reg [31:0] storeData_r;

  // Lowest set bit of a 9-bit list, bit 8 stands for LR or PC
  function [3:0] lowestBit;
    input [8:0] l;
    integer i;
    begin
      lowestBit = 4'h0;
      for (i = 8; i >= 0; i = i - 1)
        if (l[i])
          lowestBit = i[3:0];
    end
  endfunction

  function [3:0] countBits;
    input [8:0] l;
    integer i;
    begin
      countBits = 4'h0;
      for (i = 0; i < 9; i = i + 1)
        countBits = countBits + {3'h0, l[i]};
    end
  endfunction

  // Size of a transfer in low address bits that must be zero
  function [1:0] alignMask;
    input [3:0] op;
    begin
      case (op)
        `OP_LOAD_BYTE_ZX, `OP_LOAD_BYTE_SX, `OP_STORE_BYTE: alignMask = 2'b00;
        `OP_LOAD_HALF_ZX, `OP_LOAD_HALF_SX, `OP_STORE_HALF: alignMask = 2'b01;
        default: alignMask = 2'b11;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Decode of latched operation
  wire isMulti = (op_r == `OP_LOAD_MULTIPLE) || (op_r == `OP_STORE_MULTIPLE) ||
    (op_r == `OP_PUSH) || (op_r == `OP_POP);
  wire isStore = (op_r == `OP_STORE_WORD) || (op_r == `OP_STORE_BYTE) || (op_r == `OP_STORE_HALF) ||
    (op_r == `OP_STORE_MULTIPLE) || (op_r == `OP_PUSH);
  wire [3:0] curReg = lowestBit(list_r);
  // Register number of list slot 8 depends on push or pop
  wire [3:0] curRegNum = (curReg == 4'h8) ? ((op_r == `OP_PUSH) ? `REG_LR : `REG_PC) : curReg;

  // Port A: base register, or the list register to store next
  assign readAddrA = (state_r == ST_READ) ? {1'b0, base_r} : curRegNum;
  // Port B: store source at issue, then offset or first list register
  assign readAddrB = (state_r == ST_IDLE) ? {1'b0, transferReg} :
    ((state_r == ST_READ) && !isMulti) ? {1'b0, offs_r} : curRegNum;
  assign issueReady = (state_r == ST_IDLE);
  // Flags never written by this unit
  assign flagsWriteEn = 1'b0;

  wire [31:0] effAddr = readDataA + readDataB;
  wire [31:0] litAddr = {programCounter[31:2], 2'b00} + {22'h0, lit_r};
  wire [31:0] pushCount = {28'h0, countBits(list_r)} << 2;
  // First bus address of every kind of transfer, and the next word up
  wire [31:0] firstAddr = (op_r == `OP_PUSH) ? stackPointer - pushCount :
    (op_r == `OP_POP) ? stackPointer : isMulti ? readDataA :
    (op_r == `OP_LOAD_LITERAL) ? litAddr : effAddr;
  wire [31:0] nextAddr = addr_r + `WORD_BYTES;

  // Load data extraction by lane, little endian
  reg [31:0] loadVal;
  always @*
  begin
    loadVal = memRdata;
    case (op_r)
      `OP_LOAD_BYTE_ZX: loadVal = {24'h0, memRdata[8*addr_r[1:0] +: 8]};
      `OP_LOAD_BYTE_SX: loadVal = {{24{memRdata[8*addr_r[1:0]+7]}}, memRdata[8*addr_r[1:0] +: 8]};
      `OP_LOAD_HALF_ZX: loadVal = {16'h0, memRdata[16*addr_r[1] +: 16]};
      `OP_LOAD_HALF_SX: loadVal = {{16{memRdata[16*addr_r[1]+15]}}, memRdata[16*addr_r[1] +: 16]};
      default: loadVal = memRdata;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequencer
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      op_r <= 4'h0;
      xfer_r <= 3'h0;
      base_r <= 3'h0;
      offs_r <= 3'h0;
      lit_r <= 10'h0;
      list_r <= 9'h0;
      wb_r <= 1'b0;
      addr_r <= 32'h0;
      endSp_r <= 32'h0;
      pcLoaded_r <= 1'b0;
      pcVal_r <= 32'h0;
      storeData_r <= 32'h0;
      rfWriteEn <= 1'b0;
      rfWriteAddr <= 4'h0;
      rfWriteData <= 32'h0;
      memReq <= 1'b0;
      memWrite <= 1'b0;
      memAddr <= {ADDR_W{1'b0}};
      memStrobe <= 4'h0;
      memWdata <= 32'h0;
      doneOut <= 1'b0;
      branchOut <= 1'b0;
      branchTarget <= 32'h0;
      thumbBit <= 1'b1;
      faultOut <= 1'b0;
    end
    else
    begin
      rfWriteEn <= 1'b0;
      doneOut <= 1'b0;
      branchOut <= 1'b0;
      faultOut <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          if (issueValid)
          begin
            op_r <= opCode;
            xfer_r <= transferReg;
            base_r <= baseReg;
            offs_r <= offsetReg;
            lit_r <= {literalOffset[9:2], 2'b00};
            // Slot 8 only exists for push and pop
            list_r <= {listExtra & ((opCode == `OP_PUSH) || (opCode == `OP_POP)), regList};
            storeData_r <= readDataB;
            wb_r <= writeBack;
            pcLoaded_r <= 1'b0;
            state_r <= ST_READ;
          end
        end
        ST_READ:
        begin
          // Compute first address; register-offset single transfers check alignment, literal loads do not
          state_r <= ST_BUS;
          memReq <= 1'b1;
          memWrite <= isStore;
          if (op_r == `OP_PUSH)
          begin
            addr_r <= stackPointer - pushCount;
            endSp_r <= stackPointer - pushCount;
          end
          else if (op_r == `OP_POP)
          begin
            addr_r <= stackPointer;
            endSp_r <= stackPointer + pushCount;
          end
          else if (isMulti)
          begin
            addr_r <= readDataA;
            endSp_r <= readDataA + pushCount;
          end
          else if (op_r == `OP_LOAD_LITERAL)
            addr_r <= litAddr;
          else
          begin
            addr_r <= effAddr;
            if ((effAddr[1:0] & alignMask(op_r)) != 2'b00)
            begin
              // Split transfers are not supported, so abandon
              memReq <= 1'b0;
              faultOut <= 1'b1;
              doneOut <= 1'b1;
              state_r <= ST_IDLE;
            end
          end
          memAddr <= firstAddr[ADDR_W-1:0];
          // Loads get size strobes too, so the bus shows the lanes in use
          memStrobe <= (alignMask(op_r) == 2'b00) ? (`STORE_BYTE_OP_BYTE << effAddr[1:0]) :
            (alignMask(op_r) == 2'b01) ? (`STORE_BYTE_OP_HALF << {effAddr[1], 1'b0}) : `STORE_BYTE_OP_WORD;
          memWdata <= isMulti ? readDataB :
            (op_r == `OP_STORE_BYTE) ? {4{storeData_r[7:0]}} :
            (op_r == `OP_STORE_HALF) ? {2{storeData_r[15:0]}} : storeData_r;
        end
        ST_BUS:
        begin
          if (memAck)
          begin
            memReq <= 1'b0;
            if (!isStore)
            begin
              rfWriteEn <= 1'b1;
              rfWriteAddr <= isMulti ? curRegNum : {1'b0, xfer_r};
              rfWriteData <= loadVal;
              if (isMulti && curRegNum == `REG_PC)
              begin
                rfWriteEn <= 1'b0;
                pcLoaded_r <= 1'b1;
                pcVal_r <= memRdata;
              end
            end
            if (isMulti && (list_r & ~(9'h001 << curReg)) != 9'h0)
            begin
              // Next register, next word up
              list_r <= list_r & ~(9'h001 << curReg);
              addr_r <= nextAddr;
              memAddr <= nextAddr[ADDR_W-1:0];
              state_r <= ST_NEXT;
            end
            else
              state_r <= ST_FIN;
          end
        end
        ST_NEXT:
        begin
          // Port A now shows the next list register
          memReq <= 1'b1;
          memWdata <= readDataA;
          state_r <= ST_BUS;
        end
        ST_FIN:
        begin
          state_r <= ST_IDLE;
          doneOut <= 1'b1;
          if (op_r == `OP_PUSH || op_r == `OP_POP)
          begin
            rfWriteEn <= 1'b1;
            rfWriteAddr <= `REG_SP;
            rfWriteData <= endSp_r;
          end
          else if (isMulti && wb_r)
          begin
            rfWriteEn <= 1'b1;
            rfWriteAddr <= {1'b0, base_r};
            rfWriteData <= endSp_r;
          end
          if (pcLoaded_r)
          begin
            branchOut <= 1'b1;
            branchTarget <= {pcVal_r[31:1], 1'b0};
            thumbBit <= pcVal_r[0];
            faultOut <= ~pcVal_r[0];
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

endmodule // load_store_multiple_unit
`default_nettype wire

//--- lsm_chk.sv
// Port checker for the load/store multiple unit
`timescale 1ns/1ps
`default_nettype none
module lsm_chk #(
  parameter ADDR_W = 32
) (
  // Clock, reset, issue
  input wire sys_clk,
  input wire rst,
  input wire issueValid,
  input wire issueReady,
  // Bus and results
  input wire memReq,
  input wire memWrite,
  input wire [ADDR_W-1:0] memAddr,
  input wire [3:0] memStrobe,
  input wire memAck,
  input wire doneOut,
  input wire branchOut,
  input wire [31:0] branchTarget,
  input wire thumbBit,
  input wire faultOut,
  input wire flagsWriteEn
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Flags, issue and bus timing
  AST_NO_FLAGS: assert property (!flagsWriteEn) else $error("flags written");
  AST_BUSY: assert property (issueValid && issueReady |=> !issueReady) else $error("taken while busy");
  AST_START: assert property (issueValid && issueReady |-> ##2 (memReq || faultOut)) else $error("late start");
  AST_HOLD: assert property (memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWrite))
    else $error("request not held");
  AST_FAULT: assert property (faultOut |-> doneOut && !memReq) else $error("fault with access");
  AST_WORD_ALIGN: assert property (memReq && memStrobe == 4'hf |-> memAddr[1:0] == 2'h0)
    else $error("split word");
  AST_HALF_ALIGN: assert property (memReq && memStrobe inside {4'h3, 4'hc} |-> !memAddr[0])
    else $error("split half");
  AST_THUMB: assert property (branchOut |-> !branchTarget[0] && (faultOut == !thumbBit))
    else $error("state bit");
endmodule // lsm_chk
bind load_store_multiple_unit lsm_chk #(.ADDR_W(ADDR_W)) chk (.sys_clk(sys_clk), .rst(rst),
  .issueValid(issueValid), .issueReady(issueReady), .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
  .memStrobe(memStrobe), .memAck(memAck), .doneOut(doneOut), .branchOut(branchOut),
  .branchTarget(branchTarget), .thumbBit(thumbBit), .faultOut(faultOut), .flagsWriteEn(flagsWriteEn));
`default_nettype wire

//--- mem_model.sv
// Behavioural data memory on the unit's bus
`timescale 1ns/1ps
`default_nettype none
module mem_model #(
  parameter int LAT = 2
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Bus
  input wire logic memReq,
  input wire logic memWrite,
  input wire logic [31:0] memAddr,
  input wire logic [3:0] memStrobe,
  input wire logic [31:0] memWdata,
  output logic memAck,
  output logic [31:0] memRdata
);
  logic [31:0] m [0:255] = '{default: 32'h0};
  int waitCnt;
  initial memRdata = 32'h0;
  // Slow answer, one-cycle ack; data toggles when idle so stale reads show
  always @(posedge sys_clk)
  begin
    memAck <= 1'b0;
    memRdata <= ~memRdata;
    if (rst)
      waitCnt <= 0;
    else if (memReq && !memAck)
    begin
      if (waitCnt >= LAT)
      begin
        waitCnt <= 0;
        memAck <= 1'b1;
        memRdata <= m[memAddr[9:2]];
        for (int i = 0; i < 4; i++)
          if (memWrite && memStrobe[i])
            m[memAddr[9:2]][8*i+:8] <= memWdata[8*i+:8];
      end
      else
        waitCnt <= waitCnt + 1;
    end
  end
endmodule // mem_model
`default_nettype wire

//--- tb.sv
// Self-checking bench for the load/store multiple unit
`timescale 1ns/1ps
`default_nettype none
`include "lsm_consts.vh"
module tb;
  logic sys_clk, rst, issueValid, listExtra, writeBack, faultSeen;
  logic [3:0] opCode;
  logic [2:0] transferReg, baseReg, offsetReg;
  logic [9:0] literalOffset;
  logic [7:0] regList;
  logic [31:0] pcVal, brTgt;
  logic [31:0] rf [0:15];
  wire issueReady, rfWriteEn, memReq, memWrite, memAck, doneOut, branchOut, thumbBit, faultOut, flagsWriteEn;
  wire [3:0] readAddrA, readAddrB, rfWriteAddr, memStrobe;
  wire [31:0] rfWriteData, memAddr, memWdata, memRdata, branchTarget;
  int fails, cmp_count;
  //////////////////////////////////////////////
  load_store_multiple_unit uut (.sys_clk(sys_clk), .rst(rst), .issueValid(issueValid), .issueReady(issueReady),
    .opCode(opCode), .transferReg(transferReg), .baseReg(baseReg), .offsetReg(offsetReg),
    .literalOffset(literalOffset), .regList(regList), .listExtra(listExtra), .writeBack(writeBack),
    .programCounter(pcVal), .stackPointer(rf[13]), .readAddrA(readAddrA), .readDataA(rf[readAddrA]),
    .readAddrB(readAddrB), .readDataB(rf[readAddrB]), .rfWriteEn(rfWriteEn), .rfWriteAddr(rfWriteAddr),
    .rfWriteData(rfWriteData), .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr), .memStrobe(memStrobe),
    .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata), .doneOut(doneOut), .branchOut(branchOut),
    .branchTarget(branchTarget), .thumbBit(thumbBit), .faultOut(faultOut), .flagsWriteEn(flagsWriteEn));
  mem_model ram (.sys_clk(sys_clk), .rst(rst), .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
    .memStrobe(memStrobe), .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata));
  // Register file write port
  always @(posedge sys_clk)
    if (rfWriteEn)
      rf[rfWriteAddr] <= rfWriteData;
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  //////////////////////////////////////////////
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One issue, then a bounded wait for completion; pulses captured
  task automatic run(input logic [3:0] op, input logic [2:0] t, b, o, input logic [7:0] l, input logic x);
    @(posedge sys_clk);
    {opCode, transferReg, baseReg, offsetReg, regList, listExtra} <= {op, t, b, o, l, x};
    issueValid <= 1'b1;
    @(posedge sys_clk);
    issueValid <= 1'b0;
    faultSeen = 1'b0;
    repeat (200)
    begin
      @(posedge sys_clk);
      #1;
      faultSeen = faultSeen | (faultOut === 1'b1);
      if (branchOut === 1'b1)
        brTgt = branchTarget;
      if (doneOut === 1'b1)
      begin
        @(posedge sys_clk);
        #1;
        return;
      end
    end
    fails++;
    results();
  endtask
  //////////////////////////////////////////////
  task automatic t_single();
    logic [31:0] e [0:4] = '{32'h80817f7e, 32'h81, 32'h8081, 32'hffffff81, 32'hffff8081};
    ram.m[16] = 32'h80817f7e;
    rf[1] = 32'h40;
    rf[2] = 32'h2;
    rf[3] = 32'h0;
    for (int i = 0; i < 5; i++)
    begin
      run(4'(i), 3'h5, 3'h1, (i == 0) ? 3'h3 : 3'h2, 8'h0, 1'b0);
      chk(rf[5], e[i]);
    end
    run(`OP_LOAD_WORD, 3'h5, 3'h1, 3'h2, 8'h0, 1'b0);
    chk(32'(faultSeen), 32'h1);
    {rf[1], rf[2], rf[3], rf[6], rf[4]} = {32'h50, 32'h1, 32'h6, 32'h8, 32'h11223344};
    run(`OP_STORE_BYTE, 3'h4, 3'h1, 3'h2, 8'h0, 1'b0);
    run(`OP_STORE_HALF, 3'h4, 3'h1, 3'h3, 8'h0, 1'b0);
    run(`OP_STORE_WORD, 3'h4, 3'h1, 3'h6, 8'h0, 1'b0);
    chk(ram.m[20], 32'h00004400);
    chk(ram.m[21], 32'h33440000);
    chk(ram.m[22], 32'h11223344);
    ram.m[255] = 32'hcafe0001;
    pcVal = 32'h0;
    literalOffset = 10'h3fc;
    run(`OP_LOAD_LITERAL, 3'h7, 3'h0, 3'h0, 8'h0, 1'b0);
    chk(rf[7], 32'hcafe0001);
  endtask
  task automatic t_multi();
    {rf[0], rf[1], rf[2], rf[4]} = {32'ha0, 32'ha1, 32'ha2, 32'ha4};
    writeBack = 1'b1;
    run(`OP_STORE_MULTIPLE, 3'h0, 3'h0, 3'h0, 8'h16, 1'b0);
    chk(ram.m[40], 32'ha1);
    chk(ram.m[41], 32'ha2);
    chk(ram.m[42], 32'ha4);
    chk(rf[0], 32'hac);
    rf[0] = 32'ha0;
    run(`OP_LOAD_MULTIPLE, 3'h0, 3'h0, 3'h0, 8'he0, 1'b0);
    chk(rf[6], 32'ha2);
    chk(rf[7], 32'ha4);
    chk(rf[0], 32'hac);
  endtask
  task automatic t_stack();
    {rf[13], rf[14]} = {32'h200, 32'hee};
    run(`OP_PUSH, 3'h0, 3'h0, 3'h0, 8'h06, 1'b1);
    chk(ram.m[125], 32'ha1);
    chk(ram.m[127], 32'hee);
    chk(rf[13], 32'h1f4);
    ram.m[126] = 32'h301;
    run(`OP_POP, 3'h0, 3'h0, 3'h0, 8'h20, 1'b1);
    chk(rf[5], 32'ha1);
    chk(rf[13], 32'h1fc);
    chk({brTgt[31:1], thumbBit}, 32'h301);
    chk(32'(faultSeen), 32'h0);
    rf[13] = 32'h1f4;
    ram.m[126] = 32'h300;
    run(`OP_POP, 3'h0, 3'h0, 3'h0, 8'h20, 1'b1);
    chk(32'(faultSeen), 32'h1);
  endtask
  //////////////////////////////////////////////
  initial
  begin
    {rst, issueValid, listExtra, writeBack, opCode, transferReg, baseReg, offsetReg} = {1'b1, 16'h0};
    {literalOffset, regList, pcVal, brTgt} = '0;
    for (int i = 0; i < 16; i++)
      rf[i] = 32'h0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    t_single();
    t_multi();
    t_stack();
    results();
  end
endmodule // tb
`default_nettype wire
